// ==== ocint_top.sv ====
// Online command interpreter: parses frames and issues actions and answers
`default_nettype none
module ocint_top
  import ocint_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire ocint_char_t host_rx,
  input wire ocint_char_t svc_rx,
  input wire logic frame_end,
  output ocint_char_t tx_char,
  output ocint_char_t net_fwd,
  output logic copy_start,
  output ocint_copy_t copy_sel,
  output logic soft_restart,
  input wire logic copy_done,
  input wire logic [3:0] copy_result_code
);
  typedef enum {ST_CODE1, ST_CODE2, ST_PARAM1, ST_PARAM2, ST_COPY, ST_BCAST,
    ST_SKIP, ST_VER, ST_RES, ST_START} ocint_state_t;
  ocint_state_t state_reg, state_next;
  ocint_char_t tx_reg, tx_next, fwd_reg, fwd_next;
  logic start_reg, start_next, rst_req_reg, rst_req_next;
  ocint_copy_t sel_reg, sel_next;
  logic [5:0] idx_reg, idx_next;
  logic [3:0] res_reg, res_next;
  logic src_bad_reg, src_bad_next;
  ocint_char_t in_c;
  logic [7:0] up;
  logic [1:0] dig;
  // All checks run on the one clock and rest while reset is low
  default clocking ocint_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Host has priority; both ports feed the same parser
  always_comb begin
    in_c = host_rx.valid ? host_rx : svc_rx;
    up = in_c.data;
    if (up >= OCINT_LOWER_A && up <= OCINT_LOWER_Z)
      up = up & OCINT_CASE_MASK;
    dig = in_c.data[1:0];
  end
  always_comb begin
    state_next = state_reg;
    tx_next = '0;
    fwd_next = '0;
    start_next = 1'b0;
    rst_req_next = 1'b0;
    sel_next = sel_reg;
    idx_next = idx_reg;
    res_next = res_reg;
    src_bad_next = src_bad_reg;
    case (state_reg)
      ST_CODE1: begin
        if (in_c.valid) begin
          case (up)
            OCINT_CH_V: begin
              idx_next = '0;
              state_next = ST_VER;
            end
            OCINT_CH_H: begin
              rst_req_next = 1'b1;
              state_next = ST_START;
            end
            OCINT_CH_P: state_next = ST_CODE2;
            OCINT_CH_B: state_next = ST_BCAST;
            OCINT_CH_0: state_next = ST_CODE1;
            default: state_next = ST_SKIP;
          endcase
        end
      end
      ST_CODE2: if (in_c.valid)
        state_next = (up == OCINT_CH_C) ? ST_PARAM1 : ST_SKIP;
      ST_PARAM1: if (in_c.valid) begin
        sel_next.src = dig;
        // Full range check; the two low bits alone would alias '4' to '0'
        src_bad_next = (in_c.data < OCINT_CH_0) || (in_c.data > OCINT_CH_2);
        state_next = ST_PARAM2;
      end
      ST_PARAM2: if (in_c.valid) begin
        sel_next.dst = dig;
        if (in_c.data < OCINT_CH_0 || in_c.data > OCINT_CH_2 ||
            src_bad_reg) begin
          res_next = OCINT_RES_BAD_PARAM;
          state_next = ST_RES;
        end else begin
          start_next = 1'b1;
          state_next = ST_COPY;
        end
      end
      ST_COPY: if (copy_done) begin
        res_next = (copy_result_code > OCINT_RES_BAD_TYPE) ?
          OCINT_RES_BAD_TYPE : copy_result_code;
        idx_next = '0;
        state_next = ST_RES;
      end
      ST_RES: begin
        // Answer is the copy result as one ASCII digit
        tx_next = '{valid: 1'b1, data: OCINT_CH_0 + {4'h0, res_reg}};
        state_next = ST_CODE1;
      end
      ST_BCAST: begin
        if (frame_end)
          state_next = ST_CODE1;
        else if (in_c.valid)
          fwd_next = in_c;
      end
      ST_SKIP: if (frame_end)
        state_next = ST_CODE1;
      ST_VER: begin
        tx_next.valid = 1'b1;
        tx_next.data = OCINT_VER_TEXT[8*(OCINT_VER_LEN-1-int'(idx_reg)) +: 8];
        idx_next = idx_reg + 6'h1;
        if (int'(idx_reg) == OCINT_VER_LEN - 1)
          state_next = ST_CODE1;
      end
      ST_START: begin
        tx_next = '{valid: 1'b1, data: OCINT_CH_S};
        // Back to power-on values so no stale selection survives
        sel_next = '0;
        res_next = OCINT_RES_OK;
        idx_next = '0;
        src_bad_next = 1'b0;
        state_next = ST_CODE1;
      end
      default: state_next = ST_CODE1;
    endcase
    // A copy completed by the last digit is not cut by a coinciding end
    if (frame_end && state_next inside {ST_CODE2, ST_PARAM1, ST_PARAM2})
      state_next = ST_CODE1;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_CODE1;
      tx_reg <= '0;
      fwd_reg <= '0;
      start_reg <= 1'b0;
      rst_req_reg <= 1'b0;
      sel_reg <= '0;
      idx_reg <= '0;
      res_reg <= OCINT_RES_OK;
      src_bad_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tx_reg <= tx_next;
      fwd_reg <= fwd_next;
      start_reg <= start_next;
      rst_req_reg <= rst_req_next;
      sel_reg <= sel_next;
      idx_reg <= idx_next;
      res_reg <= res_next;
      src_bad_reg <= src_bad_next;
    end
  end
  assign tx_char = tx_reg;
  assign net_fwd = fwd_reg;
  assign copy_start = start_reg;
  assign copy_sel = sel_reg;
  assign soft_restart = rst_req_reg;

  // Steps of multi-cycle commands, as seen by the parser
  sequence s_ver_taken;
    state_reg == ST_CODE1 && in_c.valid && up == OCINT_CH_V;
  endsequence
  sequence s_restart_taken;
    state_reg == ST_CODE1 && in_c.valid && up == OCINT_CH_H;
  endsequence
  sequence s_copy_done_seen;
    state_reg == ST_COPY && copy_done;
  endsequence
  sequence s_bad_digit_seen;
    state_reg == ST_PARAM2 && in_c.valid && in_c.data > OCINT_CH_2;
  endsequence

  a_restart_ack: assert property (soft_restart |=>
    tx_char.valid && tx_char.data == OCINT_CH_S)
    else $error("restart not followed by start char");
  a_restart_pulse: assert property (s_restart_taken |=>
    soft_restart ##1 !soft_restart)
    else $error("restart request not a single pulse");
  a_case_fold: assert property (state_reg == ST_CODE1 && in_c.valid &&
    in_c.data == (OCINT_CH_H | ~OCINT_CASE_MASK) |=> soft_restart)
    else $error("lower case restart ignored");

  a_ver_first: assert property (s_ver_taken |=>
    ##1 tx_char.valid && tx_char.data == OCINT_CH_0)
    else $error("version answer lacks address");
  a_ver_end: assert property (state_reg == ST_VER &&
    int'(idx_reg) == OCINT_VER_LEN - 1 |=>
    tx_char.valid && tx_char.data == OCINT_CH_CR)
    else $error("version answer not closed by line end");

  a_copy_args: assert property (copy_start |->
    copy_sel.dst < OCINT_NUM_SETS)
    else $error("copy started with bad target");
  a_copy_pulse: assert property (copy_start |=> !copy_start)
    else $error("copy start longer than one cycle");
  a_bad_param: assert property (s_bad_digit_seen |=>
    !copy_start ##1 tx_char.valid &&
    tx_char.data == OCINT_CH_0 + {4'h0, OCINT_RES_BAD_PARAM})
    else $error("bad copy digit not refused");
  a_result_ack: assert property (s_copy_done_seen |=>
    ##1 tx_char.valid)
    else $error("copy result not answered");
  a_result_range: assert property (s_copy_done_seen |=>
    ##1 tx_char.data <= OCINT_CH_0 + {4'h0, OCINT_RES_BAD_TYPE})
    else $error("copy result digit out of range");

  a_bcast_quiet: assert property (state_reg == ST_BCAST |=>
    !tx_char.valid)
    else $error("broadcast answered");
  a_fwd_only: assert property (net_fwd.valid |->
    $past(state_reg) == ST_BCAST)
    else $error("forward outside broadcast");
  a_host_first: assert property (state_reg == ST_BCAST && !frame_end &&
    host_rx.valid && svc_rx.valid |=> net_fwd.data == $past(host_rx.data))
    else $error("service char won over host char");

  a_skip_silent: assert property (state_reg == ST_SKIP |=>
    !tx_char.valid && !copy_start)
    else $error("unknown frame acted upon");
  a_frame_abort: assert property (frame_end && !in_c.valid &&
    state_reg inside {ST_CODE2, ST_PARAM1, ST_PARAM2} |=>
    state_reg == ST_CODE1 && !copy_start)
    else $error("cut frame not dropped");
endmodule : ocint_top
`default_nettype wire

// ==== ocint_pkg.sv ====
// Constants and carrier types of the online command interpreter
// Summary of operation
// - A frame is a one or two letter code followed by its parameters.
// - Command letters match regardless of upper or lower case.
// - Host and service serial ports are accepted the same way.
// - Most commands are answered; some only act inside the device.
// - Version query returns type, version, date lines prefixed by address.
// - Soft restart reinitialises all, then answers one start character.
// - Copy takes source then target digit: 0 current, 1 customer, 2 factory.
// - Copy is answered with a result code 0 to 9, 0 meaning success.
// - Broadcast forwards its attached command to every slave device.
// - Broadcast itself is never answered by the master.
`default_nettype none
package ocint_pkg;
  localparam logic [7:0] OCINT_CH_V = 8'h56;
  localparam logic [7:0] OCINT_CH_H = 8'h48;
  localparam logic [7:0] OCINT_CH_P = 8'h50;
  localparam logic [7:0] OCINT_CH_C = 8'h43;
  localparam logic [7:0] OCINT_CH_B = 8'h42;
  localparam logic [7:0] OCINT_CH_S = 8'h53;
  localparam logic [7:0] OCINT_CH_0 = 8'h30;
  localparam logic [7:0] OCINT_CH_2 = 8'h32;
  localparam logic [7:0] OCINT_CH_CR = 8'h0d;
  localparam logic [7:0] OCINT_CASE_MASK = 8'hdf;
  localparam logic [7:0] OCINT_LOWER_A = 8'h61;
  localparam logic [7:0] OCINT_LOWER_Z = 8'h7a;
  localparam logic [1:0] OCINT_NUM_SETS = 2'h3;
  localparam logic [3:0] OCINT_RES_OK = 4'h0;
  localparam logic [3:0] OCINT_RES_BAD_PARAM = 4'h6;
  localparam logic [3:0] OCINT_RES_BAD_TYPE = 4'h9;
  localparam int OCINT_VER_LEN = 33;
  // Version text; content arbitrary, three address-prefixed lines
  localparam logic [8*OCINT_VER_LEN-1:0] OCINT_VER_TEXT =
    {"00DEV TYPE1", OCINT_CH_CR, "00V 00.00", OCINT_CH_CR,
     "0000.00.00", OCINT_CH_CR};
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ocint_char_t;
  typedef struct packed {
    logic [1:0] src;
    logic [1:0] dst;
  } ocint_copy_t;
endpackage : ocint_pkg
`default_nettype wire

// ==== ocint_copy_model.sv ====
// Copy engine model that answers parameter copy requests
`default_nettype none
module ocint_copy_model
  import ocint_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic copy_start,
  input wire logic [3:0] code_in,
  output logic copy_done,
  output logic [3:0] copy_result_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_reg;
  // Code is only meaningful with copy_done; otherwise show its inverse
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 4'h0;
      copy_done <= 1'b0;
      copy_result_code <= 4'hf;
    end else begin
      copy_done <= (wait_reg == 4'h1);
      copy_result_code <= (wait_reg == 4'h1) ? code_in : ~code_in;
      if (copy_start) wait_reg <= 4'h5;
      else if (wait_reg != 4'h0) wait_reg <= wait_reg - 4'h1;
    end
  end
endmodule : ocint_copy_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the online command interpreter
`default_nettype none
module testbench
  import ocint_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, frame_end, copy_start, soft_restart, copy_done;
  ocint_char_t host_rx, svc_rx, tx_char, net_fwd;
  ocint_copy_t copy_sel, sel_seen;
  logic [3:0] copy_result_code, code_in;
  logic [7:0] txq[$], fwdq[$];
  int errors, tests_run, restarts, starts;
  ocint_top ocint_top_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .host_rx(host_rx), .svc_rx(svc_rx), .frame_end(frame_end),
    .tx_char(tx_char), .net_fwd(net_fwd), .copy_start(copy_start),
    .copy_sel(copy_sel), .soft_restart(soft_restart),
    .copy_done(copy_done), .copy_result_code(copy_result_code));
  ocint_copy_model ocint_copy_model_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .copy_start(copy_start), .code_in(code_in),
    .copy_done(copy_done), .copy_result_code(copy_result_code));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (tx_char.valid === 1'b1) txq.push_back(tx_char.data);
    if (net_fwd.valid === 1'b1) fwdq.push_back(net_fwd.data);
    if (soft_restart === 1'b1) restarts++;
    if (copy_start === 1'b1) starts++;
    if (copy_start === 1'b1) sel_seen = copy_sel;
  end
  task automatic chk_char(input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) errors++;
    if (got !== exp) $display("mismatch %0t: got %h want %h", $time, got, exp);
  endtask : chk_char
  task automatic chk_num(input int exp, input int got);
    tests_run++;
    if (got != exp) errors++;
    if (got != exp) begin
      $display("mismatch %0t: count %0d want %0d", $time, got, exp);
    end
  endtask : chk_num
  // Fixed settle covers the longest answer, 33 chars plus latency
  task automatic send(input string s, input bit svc);
    txq.delete();
    fwdq.delete();
    restarts = 0;
    starts = 0;
    for (int i = 0; i < s.len(); i++) begin
      @(posedge ref_clk);
      if (svc) svc_rx <= '{1'b1, s[i]};
      else host_rx <= '{1'b1, s[i]};
    end
    @(posedge ref_clk);
    host_rx <= '{1'b0, ~s[s.len()-1]};
    svc_rx <= '{1'b0, ~s[s.len()-1]};
    repeat (60) @(posedge ref_clk);
  endtask : send
  task automatic end_frame();
    @(posedge ref_clk);
    frame_end <= 1'b1;
    @(posedge ref_clk);
    frame_end <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : end_frame
  task automatic t_restart();
    send("h", 1'b1);
    chk_num(1, restarts);
    chk_num(1, txq.size());
    chk_char(OCINT_CH_S, txq[0]);
  endtask : t_restart
  task automatic t_version();
    send("v", 1'b0);
    chk_num(OCINT_VER_LEN, txq.size());
    for (int i = 0; i < OCINT_VER_LEN; i++)
      chk_char(OCINT_VER_TEXT[8*(OCINT_VER_LEN-1-i)+:8], txq[i]);
  endtask : t_version
  task automatic t_copy();
    string cmd;
    for (int k = 0; k < 10; k++) begin
      code_in <= k[3:0];
      cmd = $sformatf("%sC%0d%0d", k[0] ? "p" : "P", k % 3, (k + 1) % 3);
      send(cmd, k[1]);
      chk_num(1, starts);
      chk_char({4'h0, 2'(k % 3), 2'((k + 1) % 3)}, {4'h0, sel_seen});
      chk_char(OCINT_CH_0 + 8'(k), txq[0]);
    end
  endtask : t_copy
  // Bad source, bad source beyond the low bits, bad target; then a cut frame
  task automatic t_bad_digit();
    string bad[3] = '{"PC31", "pc41", "PC13"};
    foreach (bad[j]) begin
      send(bad[j], 1'b0);
      chk_num(0, starts);
      chk_char(OCINT_CH_0 + 8'(OCINT_RES_BAD_PARAM), txq[0]);
    end
    send("PC1", 1'b1);
    end_frame();
    chk_num(0, starts + txq.size());
    code_in <= OCINT_RES_OK;
    send("PC20", 1'b0);
    chk_num(1, starts);
    chk_char(OCINT_CH_0 + 8'(OCINT_RES_OK), txq[0]);
  endtask : t_bad_digit
  task automatic t_broadcast();
    send("00b+V", 1'b1);
    end_frame();
    chk_num(0, txq.size());
    chk_num(2, fwdq.size());
    chk_char(8'h2b, fwdq[0]);
    chk_char(OCINT_CH_V, fwdq[1]);
  endtask : t_broadcast
  task automatic t_unknown();
    send("ZV", 1'b0);
    end_frame();
    chk_num(0, txq.size());
    send("H", 1'b0);
    chk_char(OCINT_CH_S, txq[0]);
  endtask : t_unknown
  task automatic complete_run();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #40000;
    errors++;
    complete_run();
  end
  initial begin
    {rst_n, frame_end, code_in, errors, tests_run} = '0;
    host_rx = '0;
    svc_rx = '0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_restart();
    t_version();
    t_copy();
    t_bad_digit();
    t_broadcast();
    t_unknown();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
